// ===== core/irq_lp_ctrl.sv
// interrupt sequencing, vector selection and low-power mode control
// assumes the cpu core stalls on cpu_hold and drives one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - in run, service begins only when cpu reports instruction boundary.
// - entry pushes pc, index, accumulator and condition code.
// - entry sets the global mask bit.
// - after saving, vector of serviced source is issued to pc.
// - return pops context, restoring the stacked mask and resuming program.
// - fixed priority picks one among simultaneous pending sources.
// - software trap enters regardless of mask.
// - external lines 1,2,5,6 detect rising edges.
// - external lines 3,4,7,8 detect falling edges.
// - external edge interrupts need enable bit set and mask clear.
// - masked or disabled peripheral flags stay latched pending.
// - writing zero to a flag bit clears that request.
// - status access with flag set then peripheral access clears it.
// - clearing sequence discards latched request still waiting.
// - priority reset, trap, flash, resume, ext, timer, serial, usb.
// - any interrupt wakes from wait.
// - halt left only by ext pin, usb resume or reset.
// - halt stops clocks and clears global mask.
// - halt wake holds cpu for 4096 cycles.
// - after stabilisation the waking interrupt is serviced.
// - run mode clock enable is oscillator divided by three.
// - slow select divides cpu clock further by two.
// - wait stops cpu only, forces mask clear until vectored.
// - mask cleared inside routine lets pending serviced at once.
// - context save uses five stack slots, pc low first.
module irq_lp_ctrl
    import irq_lp_pkg::*;
#(
    parameter int STAB_CYCLES = irq_lp_pkg::HALT_STAB_CYCLES
)
(
    // clock and control
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_address,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // request sources
    input wire logic [7:0] edge_wake_pin,
    input wire logic flash_req,
    input wire logic usb_resume_req,
    input wire logic timer_req,
    input wire logic serial_req,
    input wire logic usb_req,
    // cpu core
    input wire logic instr_boundary,
    input wire logic trap_instr,
    input wire logic return_from_interrupt,
    input wire logic halt_instr,
    input wire logic wait_for_interrupt_instr,
    input wire logic mask_set_sw,
    input wire logic mask_clear_sw,
    input wire logic restored_mask,
    output logic cpu_hold,
    output logic cpu_clk_en,
    output logic osc_run,
    output logic global_mask,
    output logic vector_load,
    output logic [15:0] vector_addr,
    output irq_lp_pkg::stack_op_t stack_op
);
    import irq_lp_pkg::*;

    default clocking cb_main @(posedge clock);
    endclocking
    default disable iff (srst);

    initial
    begin
        if (STAB_CYCLES < 1 || STAB_CYCLES > 65535)
            $error("STAB_CYCLES out of range");
    end

    seq_state_t state_r;
    logic [7:0] ext_enable_r;
    logic slow_r;
    logic [NUM_SRC-1:0] pen_r;
    logic [NUM_SRC-1:0] pen_arm_r;
    logic [7:0] p1_r, p2_r, p3_r;
    logic [7:0] pin_lvl_r;
    logic [NUM_SRC-1:0] src_en_r;
    logic rd_valid_r;
    logic [7:0] ext_edge;
    logic ext_pend_r;
    logic trap_pend_r;
    logic [15:0] stab_r;
    logic [2:0] ctx_r;
    logic [7:0] sp_r;
    logic [1:0] div3_r;
    logic half_r;
    logic [15:0] sel_vec_r;
    logic [NUM_SRC-1:0] src_req;
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] src_ready;
    logic any_ready;
    logic wake_halt;
    logic bus_wr, bus_rd;
    avs_req_t req;

    // vector table order
    // first set bit wins; index 0 has top priority
    function automatic logic [15:0] pick_vec(input logic tr,
                                            input logic [NUM_SRC-1:0] r);
        logic [15:0] v;
        v = VEC_USB;
        if (r[SRC_SERIAL]) v = VEC_SERIAL;
        if (r[SRC_TIMER]) v = VEC_TIMER;
        if (r[SRC_EXT]) v = VEC_EXT;
        if (r[SRC_USB_RESUME]) v = VEC_USB_RESUME;
        if (r[SRC_FLASH]) v = VEC_FLASH;
        if (tr) v = VEC_TRAP;
        return v;
    endfunction

    assign req = '{avs_read, avs_write, avs_address, avs_writedata};
    // reads take one wait state so registered data stands at acceptance
    assign avs_waitrequest = (req.read || req.write) &&
                             (!clk_en || (req.read && !rd_valid_r));
    assign bus_wr = req.write && clk_en;
    assign bus_rd = req.read && clk_en && !rd_valid_r;

    always_ff @(posedge clock)
    begin
        if (srst)
            rd_valid_r <= 1'b0;
        else if (clk_en)
            rd_valid_r <= bus_rd;
    end

    // pin synchroniser: a change counts when stages two and three agree
    always_ff @(posedge clock)
    begin
        // idle levels at reset, so release brings no false edge
        if (srst)
        begin
            p1_r <= ~RISE_MASK;
            p2_r <= ~RISE_MASK;
            p3_r <= ~RISE_MASK;
            pin_lvl_r <= ~RISE_MASK;
        end
        else if (clk_en)
        begin
            p1_r <= edge_wake_pin;
            p2_r <= p1_r;
            p3_r <= p2_r;
            pin_lvl_r <= (p2_r & p3_r) | (pin_lvl_r & (p2_r | p3_r));
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_edge
            if (RISE_MASK[g])
                assign ext_edge[g] = p2_r[g] & p3_r[g] & ~pin_lvl_r[g] &
                                     ext_enable_r[g];
            else
                assign ext_edge[g] = ~p2_r[g] & ~p3_r[g] & pin_lvl_r[g] &
                                     ext_enable_r[g];
        end
    endgenerate

    // one pending flag shared by all pins, held until serviced
    always_ff @(posedge clock)
    begin
        if (srst)
            ext_pend_r <= 1'b0;
        else if (clk_en)
        begin
            if (|ext_edge)
                ext_pend_r <= 1'b1;
            else if (state_r == ST_SAVE && ctx_r == 3'd0 &&
                     sel_vec_r == VEC_EXT)
                ext_pend_r <= 1'b0;
        end
    end

    // control and enable registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ext_enable_r <= EXT_ENABLE_RST;
            slow_r <= 1'b0;
            src_en_r <= '0;
        end
        else if (bus_wr && req.address == OFS_EXT_ENABLE)
            ext_enable_r <= req.writedata[7:0];
        else if (bus_wr && req.address == OFS_CONTROL)
        begin
            slow_r <= req.writedata[CTL_SLOW_BIT];
            src_en_r <= req.writedata[CTL_PEN_LSB +: NUM_SRC];
        end
    end

    // peripheral flags: set wins over clear
    // latch while disabled or masked
    // status access arms, peripheral access clears
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pen_r <= '0;
            pen_arm_r <= '0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (src_req[i])
                    pen_r[i] <= 1'b1;
                else if (bus_wr && req.address == OFS_STATUS &&
                         !req.writedata[i])
                    pen_r[i] <= 1'b0;
                else if ((bus_wr || bus_rd) && req.address == OFS_PERIPH &&
                         pen_arm_r[i])
                    pen_r[i] <= 1'b0;
                if ((bus_wr || bus_rd) && req.address == OFS_STATUS)
                    pen_arm_r[i] <= pen_r[i];
                else if ((bus_wr || bus_rd) && req.address == OFS_PERIPH)
                    pen_arm_r[i] <= 1'b0;
            end
        end
    end

    always_comb
    begin
        src_req = '0;
        src_req[SRC_FLASH] = flash_req;
        src_req[SRC_USB_RESUME] = usb_resume_req;
        src_req[SRC_TIMER] = timer_req;
        src_req[SRC_SERIAL] = serial_req;
        src_req[SRC_USB] = usb_req;
        src_en = src_en_r;
        src_en[SRC_EXT] = 1'b1;
    end

    // peripheral enable and clear mask both gate pending service
    always_comb
    begin
        src_ready = pen_r & src_en;
        src_ready[SRC_EXT] = ext_pend_r;
        if (global_mask)
            src_ready = '0;
    end
    assign any_ready = |src_ready || trap_pend_r;
    // only pin edges, usb resume wake the halted core
    assign wake_halt = ext_pend_r || (pen_r[SRC_USB_RESUME] &&
                                      src_en[SRC_USB_RESUME]);

    always_ff @(posedge clock)
    begin
        if (srst)
            trap_pend_r <= 1'b0;
        else if (clk_en)
        begin
            if (trap_instr)
                trap_pend_r <= 1'b1;
            else if (state_r == ST_VECTOR)
                trap_pend_r <= 1'b0;
        end
    end

    // global mask bit
    always_ff @(posedge clock)
    begin
        if (srst)
            global_mask <= 1'b1;
        else if (clk_en)
        begin
            if (state_r == ST_SAVE)
                global_mask <= 1'b1;
            else if (halt_instr || wait_for_interrupt_instr)
                global_mask <= 1'b0;
            else if (state_r == ST_POP && ctx_r == CTX_BYTES[2:0] - 3'd1)
                global_mask <= restored_mask;
            else if (mask_set_sw)
                global_mask <= 1'b1;
            else if (mask_clear_sw)
                global_mask <= 1'b0;
        end
    end

    // sequencer
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_r <= ST_RUN;
            ctx_r <= 3'd0;
            stab_r <= 16'h0000;
            sel_vec_r <= VEC_RESET;
        end
        else if (clk_en)
        begin
            case (state_r)
                ST_RUN:
                begin
                    ctx_r <= 3'd0;
                    if (halt_instr)
                        state_r <= ST_HALT;
                    else if (wait_for_interrupt_instr)
                        state_r <= ST_WAIT;
                    else if (return_from_interrupt)
                        state_r <= ST_POP;
                    else if (instr_boundary && any_ready)
                    begin
                        sel_vec_r <= pick_vec(trap_pend_r, src_ready);
                        state_r <= ST_SAVE;
                    end
                end
                // any enabled source wakes from wait
                ST_WAIT:
                    if (any_ready)
                    begin
                        sel_vec_r <= pick_vec(trap_pend_r, src_ready);
                        state_r <= ST_SAVE;
                    end
                ST_HALT:
                    if (wake_halt)
                    begin
                        stab_r <= 16'(STAB_CYCLES - 1);
                        state_r <= ST_STAB;
                    end
                ST_STAB:
                    if (stab_r == 16'h0000)
                    begin
                        sel_vec_r <= pick_vec(1'b0, src_ready);
                        state_r <= ST_SAVE;
                    end
                    else
                        stab_r <= stab_r - 16'h0001;
                ST_SAVE:
                    if (ctx_r == CTX_BYTES[2:0] - 3'd1)
                        state_r <= ST_VECTOR;
                    else
                        ctx_r <= ctx_r + 3'd1;
                ST_VECTOR:
                    state_r <= ST_RUN;
                ST_POP:
                    if (ctx_r == CTX_BYTES[2:0] - 3'd1)
                        state_r <= ST_RUN;
                    else
                        ctx_r <= ctx_r + 3'd1;
                default:
                    state_r <= ST_RUN;
            endcase
        end
    end

    // stack pointer moves one byte per slot, pc low first
    always_ff @(posedge clock)
    begin
        if (srst)
            sp_r <= SP_RESET;
        else if (clk_en)
        begin
            if (state_r == ST_SAVE)
                sp_r <= sp_r - 8'h01;
            else if (state_r == ST_POP)
                sp_r <= sp_r + 8'h01;
        end
    end
    assign stack_op = '{push: state_r == ST_SAVE,
                        pop: state_r == ST_POP,
                        stack_ptr: state_r == ST_POP ? sp_r + 8'h01 : sp_r,
                        ctx_index: ctx_r};

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            div3_r <= 2'd0;
            half_r <= 1'b0;
        end
        else if (clk_en)
        begin
            div3_r <= div3_r == 2'(RUN_DIV - 1) ? 2'd0 : div3_r + 2'd1;
            if (div3_r == 2'd0)
                half_r <= ~half_r;
        end
    end
    // gated by clk_en too: a frozen divider must not let the cpu step
    assign cpu_clk_en = clk_en && state_r != ST_HALT && state_r != ST_STAB &&
                        div3_r == 2'd0 && (!slow_r || half_r);
    assign osc_run = state_r != ST_HALT;
    assign cpu_hold = state_r != ST_RUN;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            vector_load <= 1'b0;
            vector_addr <= VEC_RESET;
        end
        else if (clk_en)
        begin
            vector_load <= state_r == ST_SAVE &&
                           ctx_r == CTX_BYTES[2:0] - 3'd1;
            if (state_r == ST_SAVE)
                vector_addr <= sel_vec_r;
        end
    end

    // register read-back
    always_ff @(posedge clock)
    begin
        if (srst)
            avs_readdata <= 32'h0000_0000;
        else if (bus_rd)
        begin
            case (req.address)
                OFS_EXT_ENABLE: avs_readdata <= {24'h000000, ext_enable_r};
                OFS_CONTROL: avs_readdata <= 32'({src_en_r, 3'b000, slow_r});
                OFS_STATUS: avs_readdata <= 32'({state_r, global_mask,
                                                 ext_pend_r, pen_r});
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    sequence s_five_pushes;
        stack_op.push [*5];
    endsequence

    a_entry_sets_mask: assert property (
        clk_en && state_r == ST_SAVE |=> global_mask)
        else $error("mask not set on entry");
    a_save_five_slots: assert property (
        $rose(stack_op.push) |-> s_five_pushes)
        else $error("context save not five slots");
    a_halt_stab_hold: assert property (
        state_r == ST_STAB && stab_r != 16'h0000 |=>
            state_r == ST_STAB && cpu_hold)
        else $error("stabilisation ended early");
    a_trap_ignores_mask: assert property (
        clk_en && state_r == ST_RUN && instr_boundary && trap_pend_r &&
        !halt_instr && !wait_for_interrupt_instr && !return_from_interrupt
        |=> state_r == ST_SAVE)
        else $error("trap blocked");
    a_halt_clears_mask: assert property (
        clk_en && halt_instr && state_r == ST_RUN |=> !global_mask)
        else $error("halt left mask set");
    a_masked_no_entry: assert property (
        global_mask && !trap_pend_r && state_r == ST_RUN |=>
            state_r != ST_SAVE)
        else $error("entry while masked");
    a_vector_after_save: assert property (
        clk_en && $rose(state_r == ST_VECTOR) |-> vector_load)
        else $error("vector not loaded");
    a_osc_off_halt: assert property (
        clk_en && halt_instr && state_r == ST_RUN |=> !osc_run)
        else $error("oscillator running in halt");
endmodule // irq_lp_ctrl

`default_nettype wire

// ===== core/irq_lp_pkg.sv
// package for the interrupt sequencer and low-power controller
// assumes a single 250 MHz clock domain and an Avalon-MM register slave
package irq_lp_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_EXT_ENABLE = 4'h8;
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_PERIPH = 4'hC;
    localparam logic [7:0] EXT_ENABLE_RST = 8'h00;
    // control register fields
    localparam int CTL_SLOW_BIT = 0;
    localparam int CTL_PEN_LSB = 4;
    // timing
    localparam int HALT_STAB_CYCLES = 4096;
    localparam int RUN_DIV = 3;
    localparam int SLOW_MUL = 2;
    localparam int CTX_BYTES = 5;
    localparam logic [7:0] SP_RESET = 8'h7F;
    // vectors, priority order index 0 = highest
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_FLASH = 16'hFFFA;
    localparam logic [15:0] VEC_USB_RESUME = 16'hFFF8;
    localparam logic [15:0] VEC_EXT = 16'hFFF6;
    localparam logic [15:0] VEC_TIMER = 16'hFFF4;
    localparam logic [15:0] VEC_SERIAL = 16'hFFF0;
    localparam logic [15:0] VEC_USB = 16'hFFEE;
    // source index in priority vector
    localparam int SRC_FLASH = 0;
    localparam int SRC_USB_RESUME = 1;
    localparam int SRC_EXT = 2;
    localparam int SRC_TIMER = 3;
    localparam int SRC_SERIAL = 4;
    localparam int SRC_USB = 5;
    localparam int NUM_SRC = 6;
    // rising-edge pins: bits 0,1,4,5; others falling
    localparam logic [7:0] RISE_MASK = 8'h33;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SAVE = 3'b001,
        ST_VECTOR = 3'b011,
        ST_WAIT = 3'b010,
        ST_HALT = 3'b110,
        ST_STAB = 3'b111,
        ST_POP = 3'b101
    } seq_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } avs_req_t;

    typedef struct packed {
        logic push;
        logic pop;
        logic [7:0] stack_ptr;
        logic [2:0] ctx_index;
    } stack_op_t;
endpackage

// ===== tb/cpu_core_model.sv
// cpu core stand-in: steps on cpu_clk_en, runs commanded instructions
// assumes the sequencer drives cpu_hold, cpu_clk_en and stack_op
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
    import irq_lp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // sequencer side
    input wire logic cpu_hold,
    input wire logic cpu_clk_en,
    input wire logic global_mask,
    input wire irq_lp_pkg::stack_op_t stack_op,
    // bench command: index of the instruction to run
    input wire logic op_go,
    input wire logic [2:0] op_code,
    output logic op_ack,
    // trap, return, halt, wait, mask set, mask clear
    output logic instr_boundary,
    output logic [5:0] instr,
    output logic restored_mask
);
    logic mask_d_r;
    logic push_d_r;
    wire logic step = cpu_clk_en && !cpu_hold && !srst;

    always_ff @(posedge clock)
    begin
        instr_boundary <= step;
        op_ack <= step && op_go;
        instr <= (step && op_go) ? 6'(1 << op_code) : 6'h00;
    end

    // stacked mask copy
    // the copy is taken a cycle early: entry may already set the mask
    always_ff @(posedge clock)
    begin
        mask_d_r <= global_mask;
        push_d_r <= stack_op.push;
        if (srst)
            restored_mask <= 1'b1;
        else if (stack_op.push && !push_d_r)
            restored_mask <= mask_d_r;
    end
endmodule // cpu_core_model
`default_nettype wire

// ===== tb/tb_irq_and_low_power_ctrl.sv
// self-checking bench for the interrupt and low-power sequencer
// assumes irq_lp_pkg and cpu_core_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_irq_and_low_power_ctrl;
    import irq_lp_pkg::*;
    // short stabilisation keeps the halt wake test brief
    localparam int stab = 8;
    typedef struct packed {logic [5:0] src; logic [15:0] vec;} row_t;
    // requests raised together and the vector that must win
    row_t rows [0:8] = '{'{6'h08, 16'hFFF4}, '{6'h10, 16'hFFF0},
        '{6'h20, 16'hFFEE}, '{6'h01, 16'hFFFA}, '{6'h02, 16'hFFF8},
        '{6'h38, 16'hFFF4}, '{6'h30, 16'hFFF0}, '{6'h23, 16'hFFFA},
        '{6'h22, 16'hFFF8}};
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // rising pins idle low, falling pins idle high
    logic [7:0] pins = 8'hCC;
    logic [5:0] src = 6'h00;
    logic op_go = 1'b0;
    logic [2:0] op_code = 3'h0;
    logic op_ack;
    logic instr_boundary;
    logic restored_mask;
    logic [5:0] instr;
    logic cpu_hold, cpu_clk_en, osc_run, global_mask, vector_load;
    logic [15:0] vector_addr;
    stack_op_t stack_op;
    logic [31:0] rd;
    int err_total = 0;
    int n_compared = 0;
    int pcnt = 0;
    int qcnt = 0;
    int n;
    int h;

    irq_lp_ctrl #(.STAB_CYCLES(stab)) u_dut
    (
        .clock(clock), .srst(srst), .clk_en(clk_en),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_address(avs_address), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .edge_wake_pin(pins), .flash_req(src[0]),
        .usb_resume_req(src[1]), .timer_req(src[3]),
        .serial_req(src[4]), .usb_req(src[5]),
        .instr_boundary(instr_boundary), .trap_instr(instr[0]),
        .return_from_interrupt(instr[1]), .halt_instr(instr[2]),
        .wait_for_interrupt_instr(instr[3]), .mask_set_sw(instr[4]),
        .mask_clear_sw(instr[5]), .restored_mask(restored_mask),
        .cpu_hold(cpu_hold), .cpu_clk_en(cpu_clk_en), .osc_run(osc_run),
        .global_mask(global_mask), .vector_load(vector_load),
        .vector_addr(vector_addr), .stack_op(stack_op)
    );

    cpu_core_model u_cpu
    (
        .clock(clock), .srst(srst), .cpu_hold(cpu_hold),
        .cpu_clk_en(cpu_clk_en), .global_mask(global_mask),
        .stack_op(stack_op), .op_go(op_go), .op_code(op_code),
        .op_ack(op_ack), .instr_boundary(instr_boundary),
        .instr(instr), .restored_mask(restored_mask)
    );

    initial
    begin
        forever #2 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // the answer is taken at the very edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clock);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic op(input logic [2:0] c);
        @(posedge clock);
        op_code <= c;
        op_go <= 1'b1;
        do @(negedge clock); while (op_ack !== 1'b1);
        @(posedge clock);
        op_go <= 1'b0;
    endtask

    task automatic pulse(input logic [5:0] s);
        @(posedge clock);
        src <= s;
        @(posedge clock);
        src <= 6'h00;
    endtask

    task automatic quiet();
        int k;
        k = 0;
        repeat (30)
        begin
            @(negedge clock);
            if (vector_load === 1'b1)
                k++;
        end
        check("spurious vector", k, 0);
    endtask

    task automatic count_en(input int exp);
        int k;
        k = 0;
        repeat (60)
        begin
            @(negedge clock);
            if (cpu_clk_en === 1'b1)
                k++;
        end
        check("cpu_clk_en count", k, exp);
    endtask

    // wait for entry, clear all flags in the routine, then return
    task automatic serve(input logic [15:0] v, input logic m);
        int t;
        t = 0;
        while (vector_load !== 1'b1 && t < 500)
        begin
            @(negedge clock);
            t++;
        end
        check("vector_load", 32'(vector_load), 32'h1);
        check("vector_addr", 32'(vector_addr), 32'(v));
        check("mask in routine", 32'(global_mask), 32'h1);
        check("pushes", pcnt, CTX_BYTES);
        pcnt = 0;
        bus(1'b1, OFS_STATUS, 32'h780);
        op(3'h1);
        quiet();
        check("pops", qcnt, CTX_BYTES);
        qcnt = 0;
        check("mask after return", 32'(global_mask), 32'(m));
    endtask

    // pc low goes first, then the rest in order
    always @(negedge clock)
    begin
        if (stack_op.push === 1'b1)
        begin
            check("ctx index", 32'(stack_op.ctx_index), pcnt);
            check("push sp", 32'(stack_op.stack_ptr),
                  32'(SP_RESET) - pcnt);
            pcnt++;
        end
        if (stack_op.pop === 1'b1)
        begin
            check("pop sp", 32'(stack_op.stack_ptr),
                  32'(SP_RESET) - CTX_BYTES + 1 + qcnt);
            qcnt++;
        end
    end

    initial
    begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        check("reset vector", 32'(vector_addr), 32'hFFFE);
        check("reset mask", 32'(global_mask), 32'h1);
        check("reset osc", 32'(osc_run), 32'h1);
        bus(1'b0, OFS_EXT_ENABLE, 32'h0);
        check("enable reset", rd, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped read", rd, 32'h0);
        count_en(20);
        @(posedge clock);
        clk_en <= 1'b0;
        count_en(0);
        @(posedge clock);
        clk_en <= 1'b1;
        bus(1'b1, OFS_CONTROL, 32'h3F1);
        count_en(10);
        bus(1'b1, OFS_CONTROL, 32'h3F0);
        bus(1'b1, OFS_EXT_ENABLE, 32'hFF);
        bus(1'b0, OFS_EXT_ENABLE, 32'h0);
        check("enable readback", rd, 32'hFF);
        op(3'h5);
        foreach (rows[i])
        begin
            pulse(rows[i].src);
            serve(rows[i].vec, 1'b0);
        end
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            pins[i] <= ~pins[i];
            serve(16'hFFF6, 1'b0);
            @(posedge clock);
            pins[i] <= ~pins[i];
            quiet();
        end
        // masked flag stays pending until the mask drops
        op(3'h4);
        pulse(6'h08);
        quiet();
        op(3'h5);
        serve(16'hFFF4, 1'b0);
        op(3'h4);
        pulse(6'h10);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("serial pending", 32'(rd[4]), 32'h1);
        bus(1'b0, OFS_PERIPH, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("serial cleared", 32'(rd[4]), 32'h0);
        op(3'h5);
        quiet();
        op(3'h4);
        op(3'h0);
        serve(16'hFFFC, 1'b1);
        op(3'h3);
        repeat (2) @(negedge clock);
        check("wait mask", 32'(global_mask), 32'h0);
        check("wait hold", 32'(cpu_hold), 32'h1);
        pulse(6'h10);
        serve(16'hFFF0, 1'b0);
        op(3'h4);
        op(3'h2);
        repeat (2) @(negedge clock);
        check("halt osc", 32'(osc_run), 32'h0);
        check("halt mask", 32'(global_mask), 32'h0);
        pulse(6'h08);
        quiet();
        check("timer no wake", 32'(osc_run), 32'h0);
        @(posedge clock);
        pins[0] <= 1'b1;
        n = 0;
        h = 0;
        while (osc_run !== 1'b1 && n < 400)
        begin
            @(negedge clock);
            n++;
        end
        n = 0;
        while (vector_load !== 1'b1 && n < 400)
        begin
            if (cpu_hold !== 1'b1)
                h++;
            @(negedge clock);
            n++;
        end
        check("stab hold", h, 0);
        check("stab len", n, stab + CTX_BYTES);
        serve(16'hFFF6, 1'b0);
        // a reset in mid-run also ends halt and fetches the reset vector
        op(3'h2);
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        check("reset leaves halt", 32'(osc_run), 32'h1);
        check("vector after reset", 32'(vector_addr), 32'hFFFE);
        check("hold after reset", 32'(cpu_hold), 32'h0);
        bus(1'b0, OFS_EXT_ENABLE, 32'h0);
        check("enable after reset", rd, 32'h0);
        complete_run();
    end

    initial
    begin
        #200000;
        err_total++;
        complete_run();
    end
endmodule // tb_irq_and_low_power_ctrl
`default_nettype wire
